// [core/sac_pkg.sv]
// Purpose: Constants and carrier types for the successive-approximation converter control
// Assumes: Nibble-wide registers on a plain address/strobe port, 100 MHz clock
package sac_pkg;
    localparam int         ADDR_W         = 6;
    localparam int         NIB_W          = 4;
    localparam logic [5:0] OFF_CHANNEL    = 6'h16;
    localparam logic [5:0] OFF_RES_LOW    = 6'h17;
    localparam logic [5:0] OFF_RES_HIGH   = 6'h18;
    localparam logic [5:0] OFF_PIN_FUNC   = 6'h19;
    localparam logic [5:0] OFF_SPEED_PIN  = 6'h1a;
    localparam logic [5:0] OFF_START      = 6'h20;
    localparam logic [5:0] OFF_IOFF       = 6'h21;
    localparam logic [5:0] OFF_PORT_DATA  = 6'h22;
    localparam logic [5:0] OFF_IRQ_STATUS = 6'h23;
    localparam logic [5:0] OFF_IRQ_MASK   = 6'h24;
    localparam int         START_BIT      = 2;
    localparam int         IOFF_BIT       = 2;
    localparam int         SPEED_BIT      = 3;
    localparam logic [3:0] RES_LOW_RST    = 4'h0;
    localparam logic [3:0] RES_HIGH_RST   = 4'h8;
    localparam logic [3:0] PORT_DATA_RST  = 4'hf;
    localparam logic [3:0] NIB_ZERO       = 4'h0;
    localparam int         CLK_MHZ        = 100;
    localparam int         STEP_FAST_NS   = 40;
    localparam int         STEP_SLOW_NS   = 160;
    localparam int         STEP_FAST_CYC  = (STEP_FAST_NS * CLK_MHZ + 999) / 1000;
    localparam int         STEP_SLOW_CYC  = (STEP_SLOW_NS * CLK_MHZ + 999) / 1000;
    localparam int         STEP_W         = 8;
    localparam int         BITS           = 8;

    typedef enum logic [1:0] {
        SAC_IDLE   = 2'b00,
        SAC_SAMPLE = 2'b01,
        SAC_STEP   = 2'b10
    } sac_state_e;

    typedef struct packed {
        logic [5:0] addr;
        logic [3:0] wdata;
        logic       wr;
        logic       rd;
    } sac_bus_s;
endpackage

// [core/sac_ctrl.sv]
// Purpose: Register file and sequencer for the 8-bit successive-approximation converter
// Assumes: Comparator output synchronised by three flops; one-cycle read latency
// Notes:   Interrupt raised on conversion done; status cleared by writing one
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module sac_ctrl #(
    parameter int STEP_FAST = sac_pkg::STEP_FAST_CYC,
    parameter int STEP_SLOW = sac_pkg::STEP_SLOW_CYC
) (
    input  wire logic                   i_mclk,
    input  wire logic                   i_reset,
    input  wire sac_pkg::sac_bus_s      i_bus,
    output var  logic [3:0]             o_rdata,
    input  wire logic                   i_comp,
    input  wire logic                   i_stop_mode,
    output var  logic [2:0]             o_channel,
    output var  logic [7:0]             o_dac_code,
    output var  logic                   o_ladder_on,
    output var  logic [7:0]             o_analog_pin,
    output var  logic [3:0]             o_port_data,
    output var  logic                   o_irq
);
    typedef struct packed {
        sac_pkg::sac_state_e st;
        logic [3:0]          chan;
        logic [3:0]          pin_func;
        logic [3:0]          speed_pin;
        logic                ioff;
        logic                busy;
        logic [3:0]          res_low;
        logic [3:0]          res_high;
        logic [3:0]          port_data;
        logic [7:0]          sar;
        logic [7:0]          trial;
        logic [7:0]          cnt;
        logic                irq_st;
        logic                irq_mask;
        logic [3:0]          rdata;
        logic [2:0]          comp_sync;
        logic                comp;
        logic                irq;
        logic                ladder_on;
        logic [7:0]          apin;
    } sac_reg_s;

    sac_reg_s r;
    sac_reg_s next_r;
    logic     wr_start;
    logic     done;

    function automatic logic [7:0] step_len(input logic slow);
        step_len = slow ? 8'(STEP_SLOW) : 8'(STEP_FAST);
    endfunction

    function automatic logic hit(input logic [5:0] a, input logic [5:0] off);
        hit = (a == off);
    endfunction

    always_comb begin
        next_r = r;
        done = 1'b0;
        wr_start = i_bus.wr && hit(i_bus.addr, sac_pkg::OFF_START)
                   && i_bus.wdata[sac_pkg::START_BIT];
        // Comparator synchroniser; decision taken once stages 2 and 3 agree
        next_r.comp_sync = {r.comp_sync[1:0], i_comp};
        if (r.comp_sync[2] == r.comp_sync[1]) begin
            next_r.comp = r.comp_sync[2];
        end
        if (i_bus.wr) begin
            case (i_bus.addr)
                sac_pkg::OFF_CHANNEL: begin
                    next_r.chan = i_bus.wdata;
                end
                sac_pkg::OFF_PIN_FUNC: begin
                    next_r.pin_func = i_bus.wdata;
                end
                sac_pkg::OFF_SPEED_PIN: begin
                    next_r.speed_pin = i_bus.wdata;
                end
                sac_pkg::OFF_IOFF: begin
                    next_r.ioff = i_bus.wdata[sac_pkg::IOFF_BIT];
                end
                sac_pkg::OFF_PORT_DATA: begin
                    next_r.port_data = i_bus.wdata;
                end
                sac_pkg::OFF_IRQ_STATUS: begin
                    if (i_bus.wdata[0]) begin
                        next_r.irq_st = 1'b0;
                    end
                end
                sac_pkg::OFF_IRQ_MASK: begin
                    next_r.irq_mask = i_bus.wdata[0];
                end
                default: begin
                end
            endcase
        end
        case (r.st)
            sac_pkg::SAC_IDLE: begin
                if (wr_start && !i_stop_mode) begin
                    next_r.busy  = 1'b1;
                    next_r.st    = sac_pkg::SAC_SAMPLE;
                    next_r.trial = 8'h80;
                    next_r.sar   = 8'h80;
                    next_r.cnt   = step_len(r.speed_pin[sac_pkg::SPEED_BIT]);
                end
            end
            sac_pkg::SAC_SAMPLE, sac_pkg::SAC_STEP: begin
                if (i_stop_mode) begin
                    next_r.st   = sac_pkg::SAC_IDLE;
                    next_r.busy = 1'b0;
                end else if (r.cnt > 8'h1) begin
                    next_r.cnt = r.cnt - 8'h1;
                end else begin
                    // Keep trial bit if input is above ladder level, judged on this cycle's accepted value
                    if (!next_r.comp) begin
                        next_r.sar = r.sar & ~r.trial;
                    end
                    next_r.cnt = step_len(r.speed_pin[sac_pkg::SPEED_BIT]);
                    if (r.trial == 8'h01) begin
                        done = 1'b1;
                        next_r.st = sac_pkg::SAC_IDLE;
                        next_r.busy = 1'b0;
                        next_r.res_high = next_r.sar[7:4];
                        next_r.res_low  = next_r.sar[3:0];
                    end else begin
                        next_r.st    = sac_pkg::SAC_STEP;
                        next_r.trial = r.trial >> 1;
                        next_r.sar   = next_r.sar | (r.trial >> 1);
                    end
                end
            end
            default: begin
                next_r.st = sac_pkg::SAC_IDLE;
            end
        endcase
        if (done) begin
            next_r.irq_st = 1'b1;
        end
        next_r.rdata = sac_pkg::NIB_ZERO;
        if (i_bus.rd) begin
            case (i_bus.addr)
                sac_pkg::OFF_CHANNEL:    next_r.rdata = r.chan;
                sac_pkg::OFF_RES_LOW:    next_r.rdata = r.res_low;
                sac_pkg::OFF_RES_HIGH:   next_r.rdata = r.res_high;
                sac_pkg::OFF_PIN_FUNC:   next_r.rdata = r.pin_func;
                sac_pkg::OFF_SPEED_PIN:  next_r.rdata = r.speed_pin;
                sac_pkg::OFF_START:      next_r.rdata = {1'b0, r.busy, 2'b00};
                sac_pkg::OFF_IOFF:       next_r.rdata = {1'b0, r.ioff, 2'b00};
                sac_pkg::OFF_PORT_DATA:  next_r.rdata = r.port_data;
                sac_pkg::OFF_IRQ_STATUS: next_r.rdata = {3'b000, r.irq_st};
                sac_pkg::OFF_IRQ_MASK:   next_r.rdata = {3'b000, r.irq_mask};
                default:                 next_r.rdata = sac_pkg::NIB_ZERO;
            endcase
        end
        next_r.irq = next_r.irq_st & next_r.irq_mask;
        next_r.ladder_on = next_r.busy && !next_r.ioff && !i_stop_mode;
        next_r.apin = {next_r.speed_pin[1:0], next_r.speed_pin[2], 1'b0,
                       next_r.pin_func} & 8'hef;
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            r           <= '0;
            r.st        <= sac_pkg::SAC_IDLE;
            r.res_low   <= sac_pkg::RES_LOW_RST;
            r.res_high  <= sac_pkg::RES_HIGH_RST;
            r.port_data <= sac_pkg::PORT_DATA_RST;
        end else begin
            r <= next_r;
        end
    end

    assign o_rdata      = r.rdata;
    assign o_channel    = r.chan[2:0];
    assign o_dac_code   = r.sar;
    assign o_ladder_on  = r.ladder_on;
    assign o_analog_pin = r.apin;
    assign o_port_data  = r.port_data;
    assign o_irq        = r.irq;

    property p_done_clears;
        @(posedge i_mclk) disable iff (i_reset)
        done |=> !r.busy && r.irq_st;
    endproperty
    a_done_clears: assert property (p_done_clears) else $error("Done did not clear busy");

    property p_start_busy;
        @(posedge i_mclk) disable iff (i_reset)
        (r.st == sac_pkg::SAC_IDLE && wr_start && !i_stop_mode) |=> r.busy;
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("Start did not set busy");

    property p_stop_ladder;
        @(posedge i_mclk) disable iff (i_reset)
        i_stop_mode |=> !r.ladder_on;
    endproperty
    a_stop_ladder: assert property (p_stop_ladder) else $error("Ladder on in stop");

    property p_ioff;
        @(posedge i_mclk) disable iff (i_reset)
        r.ioff |-> !r.ladder_on;
    endproperty
    a_ioff: assert property (p_ioff) else $error("Ladder on while off flag set");

    property p_split;
        @(posedge i_mclk) disable iff (i_reset)
        done |=> {r.res_high, r.res_low} == $past(next_r.sar);
    endproperty
    a_split: assert property (p_split) else $error("Result split wrong");

    property p_result_stable;
        @(posedge i_mclk) disable iff (i_reset)
        !done |=> $stable({r.res_high, r.res_low});
    endproperty
    a_result_stable: assert property (p_result_stable) else $error("Result moved");

    property p_chan_write;
        @(posedge i_mclk) disable iff (i_reset)
        (i_bus.wr && i_bus.addr == sac_pkg::OFF_CHANNEL) |=> o_channel == $past(i_bus.wdata[2:0]);
    endproperty
    a_chan_write: assert property (p_chan_write) else $error("Channel not stored");

    property p_busy_read;
        @(posedge i_mclk) disable iff (i_reset)
        (i_bus.rd && i_bus.addr == sac_pkg::OFF_START) |=> o_rdata[2] == $past(r.busy);
    endproperty
    a_busy_read: assert property (p_busy_read) else $error("Busy read wrong");

    property p_reset_low;
        @(posedge i_mclk) disable iff (i_reset)
        $fell(i_reset) |-> r.res_low == sac_pkg::RES_LOW_RST;
    endproperty
    a_reset_low: assert property (p_reset_low) else $error("Low result reset wrong");

    property p_reset_high;
        @(posedge i_mclk) disable iff (i_reset)
        $fell(i_reset) |-> r.res_high == sac_pkg::RES_HIGH_RST;
    endproperty
    a_reset_high: assert property (p_reset_high) else $error("High result reset wrong");

    property p_reset_port;
        @(posedge i_mclk) disable iff (i_reset)
        $fell(i_reset) |-> r.port_data == sac_pkg::PORT_DATA_RST;
    endproperty
    a_reset_port: assert property (p_reset_port) else $error("Port data reset wrong");

    property p_stop_idle;
        @(posedge i_mclk) disable iff (i_reset)
        i_stop_mode |=> !r.busy;
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("Busy in stop");

    property p_trial_onehot;
        @(posedge i_mclk) disable iff (i_reset)
        r.busy |-> $onehot(r.trial);
    endproperty
    a_trial_onehot: assert property (p_trial_onehot) else $error("Trial not one-hot");

    property p_trial_walk;
        @(posedge i_mclk) disable iff (i_reset)
        (r.busy && r.cnt == 8'h01 && r.trial != 8'h01 && !i_stop_mode) |=>
            r.trial == ($past(r.trial) >> 1);
    endproperty
    a_trial_walk: assert property (p_trial_walk) else $error("Trial did not move down");

    property p_trial_in_code;
        @(posedge i_mclk) disable iff (i_reset)
        r.busy |-> (r.sar & r.trial) == r.trial;
    endproperty
    a_trial_in_code: assert property (p_trial_in_code) else $error("Trial bit not in code");

    property p_code_hold;
        @(posedge i_mclk) disable iff (i_reset)
        (r.busy && r.cnt > 8'h01 && !i_stop_mode) |=> $stable(r.sar);
    endproperty
    a_code_hold: assert property (p_code_hold) else $error("Code moved inside a step");

    property p_step_len;
        @(posedge i_mclk) disable iff (i_reset)
        (r.st == sac_pkg::SAC_IDLE && wr_start && !i_stop_mode) |=>
            r.cnt == (r.speed_pin[sac_pkg::SPEED_BIT] ? 8'(STEP_SLOW) : 8'(STEP_FAST));
    endproperty
    a_step_len: assert property (p_step_len) else $error("Step length wrong");

    property p_done_last;
        @(posedge i_mclk) disable iff (i_reset)
        done |-> r.busy && r.trial == 8'h01;
    endproperty
    a_done_last: assert property (p_done_last) else $error("Done before last bit");

    property p_irq_level;
        @(posedge i_mclk) disable iff (i_reset)
        r.irq == (r.irq_st && r.irq_mask);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("Interrupt level wrong");

    property p_irq_clear;
        @(posedge i_mclk) disable iff (i_reset)
        (i_bus.wr && i_bus.addr == sac_pkg::OFF_IRQ_STATUS && i_bus.wdata[0] && !done) |=>
            !r.irq_st;
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("Status not cleared");

    property p_rdata_idle;
        @(posedge i_mclk) disable iff (i_reset)
        !i_bus.rd |=> o_rdata == sac_pkg::NIB_ZERO;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("Read data without read");

    property p_read_low;
        @(posedge i_mclk) disable iff (i_reset)
        (i_bus.rd && i_bus.addr == sac_pkg::OFF_RES_LOW) |=> o_rdata == $past(r.res_low);
    endproperty
    a_read_low: assert property (p_read_low) else $error("Low result read wrong");

    property p_read_high;
        @(posedge i_mclk) disable iff (i_reset)
        (i_bus.rd && i_bus.addr == sac_pkg::OFF_RES_HIGH) |=> o_rdata == $past(r.res_high);
    endproperty
    a_read_high: assert property (p_read_high) else $error("High result read wrong");

    property p_ladder_busy;
        @(posedge i_mclk) disable iff (i_reset)
        r.ladder_on |-> r.busy;
    endproperty
    a_ladder_busy: assert property (p_ladder_busy) else $error("Ladder on while idle");

    property p_ladder_conv;
        @(posedge i_mclk) disable iff (i_reset)
        (r.busy && !r.ioff && !$past(i_stop_mode)) |-> r.ladder_on;
    endproperty
    a_ladder_conv: assert property (p_ladder_conv) else $error("Ladder off in conversion");

    property p_port_write;
        @(posedge i_mclk) disable iff (i_reset)
        (i_bus.wr && i_bus.addr == sac_pkg::OFF_PORT_DATA) |=> o_port_data == $past(i_bus.wdata);
    endproperty
    a_port_write: assert property (p_port_write) else $error("Port data not stored");

    property p_pin_map;
        @(posedge i_mclk) disable iff (i_reset)
        r.apin[3:0] == r.pin_func;
    endproperty
    a_pin_map: assert property (p_pin_map) else $error("Pin function map wrong");

    property p_speed_map;
        @(posedge i_mclk) disable iff (i_reset)
        r.apin[7:4] == {r.speed_pin[1:0], r.speed_pin[2], 1'b0};
    endproperty
    a_speed_map: assert property (p_speed_map) else $error("Speed pin map wrong");
endmodule
`default_nettype wire

// [verification/sac_src.sv]
// Purpose: Analog sources and comparator on the far side of the converter
// Assumes: Comparator judges the selected level against the trial code
// Notes:   Ladder off gives a comparator output that toggles every cycle
`timescale 1ns/10ps
`default_nettype none
module sac_src (
    input  wire logic            i_mclk,
    input  wire logic [2:0]      i_channel,
    input  wire logic [7:0]      i_dac_code,
    input  wire logic            i_ladder_on,
    input  wire logic [7:0][7:0] i_level,
    output var  logic            o_comp
);
    logic toggle;
    initial toggle = 1'b0;
    // Comparator is analog: it follows the code at once, the block synchronises it
    always @(posedge i_mclk) begin
        toggle <= ~toggle;
    end
    always_comb begin
        o_comp = i_ladder_on ? (i_level[i_channel] > i_dac_code) : toggle;
    end
endmodule
`default_nettype wire

// [verification/tb.sv]
// Purpose: Self-checking bench for the converter control
// Assumes: Register port with one-cycle read data, mask bit 0 enables the interrupt
// Notes:   Expected results come from a behavioural approximation model
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic              i_mclk, i_reset, comp, stop, irq, ladder;
    sac_pkg::sac_bus_s bus;
    logic [3:0]        rdata, pdata, a, b;
    logic [2:0]        chan;
    logic [7:0]        dac, apin, r;
    logic [7:0][7:0]   level;
    int                errors, checked, cyc, seed, k;

    sac_ctrl uut (.i_mclk(i_mclk), .i_reset(i_reset), .i_bus(bus), .o_rdata(rdata),
        .i_comp(comp), .i_stop_mode(stop), .o_channel(chan), .o_dac_code(dac),
        .o_ladder_on(ladder), .o_analog_pin(apin), .o_port_data(pdata), .o_irq(irq));
    sac_src src (.i_mclk(i_mclk), .i_channel(chan), .i_dac_code(dac),
        .i_ladder_on(ladder), .i_level(level), .o_comp(comp));

    function automatic logic [7:0] sar(input logic [7:0] v);
        logic [7:0] t;
        t = 8'h00;
        for (int i = 7; i >= 0; i--) if (v > (t | (8'h01 << i))) t = t | (8'h01 << i);
        return t;
    endfunction

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask

    task automatic wr(input logic [5:0] ad, input logic [3:0] wd);
        bus <= '{ad, wd, 1'b1, 1'b0};
        @(posedge i_mclk);
        bus.wr <= 1'b0;
        @(posedge i_mclk);
    endtask

    task automatic rdchk(input logic [5:0] ad, input logic [3:0] exp);
        bus <= '{ad, 4'h0, 1'b0, 1'b1};
        @(posedge i_mclk);
        bus.rd <= 1'b0;
        #1 chk({4'h0, rdata}, {4'h0, exp});
        @(posedge i_mclk);
    endtask

    task automatic wrap_up();
        $display("counts: checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end

    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            wrap_up();
        end
    end

    initial begin
        seed = 32'hb89d;
        i_reset = 1'b1;
        bus = '0;
        stop = 1'b0;
        for (k = 0; k < 8; k++) level[k] = 8'($random(seed));
        repeat (6) @(posedge i_mclk);
        i_reset <= 1'b0;
        rdchk(sac_pkg::OFF_RES_LOW, 4'h0);
        rdchk(sac_pkg::OFF_RES_HIGH, 4'h8);
        rdchk(sac_pkg::OFF_PORT_DATA, 4'hf);
        rdchk(6'h3f, 4'h0);
        wr(sac_pkg::OFF_RES_LOW, 4'hf);
        wr(sac_pkg::OFF_RES_HIGH, 4'h0);
        rdchk(sac_pkg::OFF_RES_LOW, 4'h0);
        rdchk(sac_pkg::OFF_RES_HIGH, 4'h8);
        wr(sac_pkg::OFF_PORT_DATA, 4'h0);
        rdchk(sac_pkg::OFF_PORT_DATA, 4'h0);
        chk({4'h0, pdata}, 8'h00);
        a = 4'($random(seed));
        b = 4'($random(seed));
        wr(sac_pkg::OFF_PIN_FUNC, a);
        wr(sac_pkg::OFF_SPEED_PIN, b);
        step(2);
        chk(apin, {b[1:0], b[2], 1'b0, a});
        rdchk(sac_pkg::OFF_PIN_FUNC, a);
        rdchk(sac_pkg::OFF_SPEED_PIN, b);
        $display("test registers done");
        wr(sac_pkg::OFF_IRQ_MASK, 4'h1);
        for (k = 0; k < 16; k++) begin
            r = sar(level[k[2:0]]);
            wr(sac_pkg::OFF_CHANNEL, {1'b0, k[2:0]});
            wr(sac_pkg::OFF_SPEED_PIN, {k[3], b[2:0]});
            wr(sac_pkg::OFF_START, 4'h4);
            step(2);
            chk({5'h0, chan}, {5'h0, k[2:0]});
            rdchk(sac_pkg::OFF_CHANNEL, {1'b0, k[2:0]});
            chk({7'h0, ladder}, 8'h01);
            rdchk(sac_pkg::OFF_START, 4'h4);
            for (int n = 0; n < 400 && irq !== 1'b1; n++) step(1);
            chk({7'h0, irq}, 8'h01);
            rdchk(sac_pkg::OFF_START, 4'h0);
            rdchk(sac_pkg::OFF_RES_HIGH, r[7:4]);
            rdchk(sac_pkg::OFF_RES_LOW, r[3:0]);
            if (k == 0) begin
                rdchk(sac_pkg::OFF_IRQ_STATUS, 4'h1);
                rdchk(sac_pkg::OFF_IRQ_MASK, 4'h1);
                wr(sac_pkg::OFF_IRQ_STATUS, 4'h0);
                step(2);
                chk({7'h0, irq}, 8'h01);
                wr(sac_pkg::OFF_IRQ_MASK, 4'h0);
                step(2);
                chk({7'h0, irq}, 8'h00);
                wr(sac_pkg::OFF_IRQ_MASK, 4'h1);
                step(2);
                chk({7'h0, irq}, 8'h01);
            end
            wr(sac_pkg::OFF_IRQ_STATUS, 4'h1);
            step(2);
            chk({7'h0, irq}, 8'h00);
        end
        $display("test conversions done");
        wr(sac_pkg::OFF_SPEED_PIN, 4'h0);
        wr(sac_pkg::OFF_IOFF, 4'h4);
        rdchk(sac_pkg::OFF_IOFF, 4'h4);
        wr(sac_pkg::OFF_START, 4'h4);
        step(2);
        chk({7'h0, ladder}, 8'h00);
        stop <= 1'b1;
        step(3);
        rdchk(sac_pkg::OFF_START, 4'h0);
        wr(sac_pkg::OFF_IOFF, 4'h0);
        wr(sac_pkg::OFF_START, 4'h4);
        step(2);
        rdchk(sac_pkg::OFF_START, 4'h0);
        chk({7'h0, ladder}, 8'h00);
        rdchk(sac_pkg::OFF_RES_HIGH, r[7:4]);
        rdchk(sac_pkg::OFF_RES_LOW, r[3:0]);
        stop <= 1'b0;
        $display("test ladder and stop done");
        i_reset <= 1'b1;
        step(6);
        i_reset <= 1'b0;
        rdchk(sac_pkg::OFF_RES_LOW, 4'h0);
        rdchk(sac_pkg::OFF_RES_HIGH, 4'h8);
        rdchk(sac_pkg::OFF_PORT_DATA, 4'hf);
        chk({4'h0, pdata}, 8'h0f);
        $display("test reset done");
        wrap_up();
    end
endmodule
`default_nettype wire
